// *** shared/cpj_pkg.sv ***
package cpj_pkg;

  // boundary-scan controller states
  typedef enum logic [3:0] {
    TAP_RESET = 4'b1111,
    TAP_IDLE = 4'b1100,
    TAP_SELDR = 4'b0111,
    TAP_CAPDR = 4'b0110,
    TAP_SHDR = 4'b0010,
    TAP_EX1DR = 4'b0001,
    TAP_PADR = 4'b0011,
    TAP_EX2DR = 4'b0000,
    TAP_UPDR = 4'b0101,
    TAP_SELIR = 4'b0100,
    TAP_CAPIR = 4'b1110,
    TAP_SHIR = 4'b1010,
    TAP_EX1IR = 4'b1001,
    TAP_PAIR = 4'b1011,
    TAP_EX2IR = 4'b1000,
    TAP_UPIR = 4'b1101
  } cpj_tap_state_t;

  // configuration sequencer states
  typedef enum logic [1:0] {
    CFG_CLEAR = 2'b00,
    CFG_LOAD = 2'b01,
    CFG_DONE = 2'b10,
    CFG_SUSP = 2'b11
  } cpj_cfg_state_t;

  localparam int IR_W = 4;
  localparam logic [3:0] INS_BYPASS = 4'hf;
  localparam logic [3:0] INS_IDCODE = 4'h1;
  localparam logic [3:0] INS_USER = 4'h2;
  localparam logic [3:0] INS_STATUS = 4'h3;
  localparam logic [3:0] INS_REPROG = 4'h4;
  localparam logic [3:0] IR_CAPTURE = 4'h1;

  localparam int DR_W = 32;
  localparam int DR_IDX_W = 5;
  localparam int USER_W_DEF = 8;
  localparam int STATUS_W = 2;
  localparam int LOAD_CYCLES_DEF = 16;

  // arbitrary identification value
  localparam logic [31:0] ID_CODE_DEF = 32'h0c0f_fee1;

endpackage

// *** shared/cpj_tap_if.sv ***
`timescale 1ns/10ps
interface cpj_tap_if;
  import cpj_pkg::*;

  logic tms;
  cpj_tap_state_t state;

  modport fsm (input tms, output state);
  modport user (output tms, input state);
endinterface

// *** rtl/cpj_sync.sv ***
`timescale 1ns/10ps
module cpj_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic enable,
  // data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_q;

  always_comb
  begin
    next_stage1 = enable ? d : stage1;
    next_q = enable ? stage1 : q;
  end

  // stage1 feeds only the second flop
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      stage1 <= '0;
      q <= '0;
    end
    else
    begin
      stage1 <= next_stage1;
      q <= next_q;
    end
  end

endmodule

// *** rtl/cpj_tap_fsm.sv ***
`timescale 1ns/10ps
module cpj_tap_fsm
  import cpj_pkg::*;
(
  // test clock and power-on reset only
  input wire logic tck,
  input wire logic reset,
  // controller state
  cpj_tap_if.fsm bus
);

  cpj_tap_state_t next_state;

  always_comb
  begin
    case (bus.state)
      TAP_RESET: next_state = bus.tms ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: next_state = bus.tms ? TAP_SELDR : TAP_IDLE;
      TAP_SELDR: next_state = bus.tms ? TAP_SELIR : TAP_CAPDR;
      TAP_CAPDR: next_state = bus.tms ? TAP_EX1DR : TAP_SHDR;
      TAP_SHDR: next_state = bus.tms ? TAP_EX1DR : TAP_SHDR;
      TAP_EX1DR: next_state = bus.tms ? TAP_UPDR : TAP_PADR;
      TAP_PADR: next_state = bus.tms ? TAP_EX2DR : TAP_PADR;
      TAP_EX2DR: next_state = bus.tms ? TAP_UPDR : TAP_SHDR;
      TAP_UPDR: next_state = bus.tms ? TAP_SELDR : TAP_IDLE;
      TAP_SELIR: next_state = bus.tms ? TAP_RESET : TAP_CAPIR;
      TAP_CAPIR: next_state = bus.tms ? TAP_EX1IR : TAP_SHIR;
      TAP_SHIR: next_state = bus.tms ? TAP_EX1IR : TAP_SHIR;
      TAP_EX1IR: next_state = bus.tms ? TAP_UPIR : TAP_PAIR;
      TAP_PAIR: next_state = bus.tms ? TAP_EX2IR : TAP_PAIR;
      TAP_EX2IR: next_state = bus.tms ? TAP_UPIR : TAP_SHIR;
      TAP_UPIR: next_state = bus.tms ? TAP_SELDR : TAP_IDLE;
      default: next_state = TAP_RESET;
    endcase
  end

  // program reset deliberately absent here
  always_ff @(posedge tck or posedge reset)
  begin
    if (reset)
      bus.state <= TAP_RESET;
    else
      bus.state <= next_state;
  end

  sequence tmsHigh5;
    bus.tms [*5];
  endsequence

  a_tap_five_ones: assert property (@(posedge tck) disable iff (reset)
    tmsHigh5 |=> bus.state == TAP_RESET)
    else $error("five tms ones did not reach reset state");

  a_tap_idle_exit: assert property (@(posedge tck) disable iff (reset)
    (bus.state == TAP_IDLE && bus.tms) |=> bus.state == TAP_SELDR)
    else $error("idle did not follow tms high");

  a_tap_capture_shift: assert property (@(posedge tck) disable iff (reset)
    (bus.state == TAP_CAPDR && !bus.tms) |=> bus.state == TAP_SHDR)
    else $error("capture did not enter shift on tms low");

endmodule

// *** rtl/cpj_config_pins.sv ***
`timescale 1ns/10ps
module cpj_config_pins
  import cpj_pkg::*;
#(
  parameter int LOAD_CYCLES = LOAD_CYCLES_DEF,
  parameter int USER_W = USER_W_DEF,
  // arbitrary identification value
  parameter logic [31:0] ID_CODE = ID_CODE_DEF
) (
  // system clock and reset
  input wire logic clock,
  input wire logic reset,
  input wire logic clockEnable,
  // configuration pins
  input wire logic programResetN,
  input wire logic suspendPin,
  output logic configDone,
  output logic suspendActive,
  // test access port
  input wire logic tck,
  input wire logic tms,
  input wire logic tmsPresent,
  input wire logic tdi,
  input wire logic tdiPresent,
  output logic tdo,
  output logic tdoOe,
  // user data register, tck domain
  output logic [USER_W-1:0] userData
);

  localparam int CNT_W = $clog2(LOAD_CYCLES + 1);
  localparam logic [CNT_W-1:0] LOAD_LAST = CNT_W'(LOAD_CYCLES - 1);

  logic coreReset;
  logic tdiEff;
  logic inShift;
  logic shiftDr;
  logic shiftIr;
  logic [1:0] coreSyncQ;
  logic [1:0] tckSyncQ;
  logic reprogEdge;

  // tck domain state
  logic [IR_W-1:0] irShift;
  logic [IR_W-1:0] irReg;
  logic [DR_W-1:0] drShift;
  logic [DR_IDX_W-1:0] drTop;
  logic reprogToggle;
  logic [IR_W-1:0] next_irShift;
  logic [IR_W-1:0] next_irReg;
  logic [DR_W-1:0] next_drShift;
  logic [USER_W-1:0] next_userData;
  logic next_reprogToggle;
  logic next_tdo;
  logic next_tdoOe;

  // core domain state
  cpj_cfg_state_t cfgState;
  cpj_cfg_state_t next_cfgState;
  logic [CNT_W-1:0] loadCount;
  logic [CNT_W-1:0] next_loadCount;
  logic next_configDone;
  logic next_suspendActive;
  logic reprogLast;
  logic next_reprogLast;
  logic progPulse;
  logic [1:0] progHold;
  logic [1:0] next_progHold;

  cpj_tap_if tapBus();

  // async on purpose: the pin must act even with the clock stopped
  assign progPulse = ~programResetN;
  assign coreReset = reset | progPulse | progHold[1];

  // pad keeper: a floating pin reads high
  assign tapBus.tms = tmsPresent ? tms : 1'b1;
  assign tdiEff = tdiPresent ? tdi : 1'b1;

  assign shiftDr = (tapBus.state == TAP_SHDR);
  assign shiftIr = (tapBus.state == TAP_SHIR);
  assign inShift = shiftDr | shiftIr;

  // controller on tck with power-on reset only
  cpj_tap_fsm uTapFsm (
    .tck(tck),
    .reset(reset),
    .bus(tapBus.fsm)
  );

  // status into tck domain
  cpj_sync #(.WIDTH(2)) uTckSync (
    .clk(tck),
    .reset(reset),
    .enable(1'b1),
    .d({suspendActive, configDone}),
    .q(tckSyncQ)
  );

  // suspend pin and reprogram toggle into core domain
  cpj_sync #(.WIDTH(2)) uCoreSync (
    .clk(clock),
    .reset(reset),
    .enable(clockEnable),
    .d({reprogToggle, suspendPin}),
    .q(coreSyncQ)
  );

  // top bit index of the selected data register
  always_comb
  begin
    case (irReg)
      INS_IDCODE: drTop = DR_IDX_W'(DR_W - 1);
      INS_USER: drTop = DR_IDX_W'(USER_W - 1);
      INS_STATUS: drTop = DR_IDX_W'(STATUS_W - 1);
      default: drTop = '0;
    endcase
  end

  always_comb
  begin
    next_irShift = irShift;
    next_irReg = irReg;
    next_drShift = drShift;
    next_userData = userData;
    next_reprogToggle = reprogToggle;
    case (tapBus.state)
      TAP_RESET: next_irReg = INS_IDCODE;
      TAP_CAPIR: next_irShift = IR_CAPTURE;
      TAP_SHIR: next_irShift = {tdiEff, irShift[IR_W-1:1]};
      TAP_UPIR: next_irReg = irShift;
      TAP_CAPDR:
      begin
        case (irReg)
          INS_IDCODE: next_drShift = ID_CODE;
          INS_USER: next_drShift = {{(DR_W-USER_W){1'b0}}, userData};
          INS_STATUS: next_drShift = {{(DR_W-STATUS_W){1'b0}}, tckSyncQ};
          default: next_drShift = '0;
        endcase
      end
      TAP_SHDR:
      begin
        next_drShift = drShift >> 1;
        next_drShift[drTop] = tdiEff;
      end
      TAP_UPDR:
      begin
        if (irReg == INS_USER)
          next_userData = drShift[USER_W-1:0];
        // event crosses as a toggle
        if (irReg == INS_REPROG)
          next_reprogToggle = ~reprogToggle;
      end
      default:
      begin
        next_irShift = irShift;
      end
    endcase
  end

  always_ff @(posedge tck or posedge reset)
  begin
    if (reset)
    begin
      irShift <= '0;
      irReg <= INS_IDCODE;
      drShift <= '0;
      userData <= '0;
      reprogToggle <= 1'b0;
    end
    else
    begin
      irShift <= next_irShift;
      irReg <= next_irReg;
      drShift <= next_drShift;
      userData <= next_userData;
      reprogToggle <= next_reprogToggle;
    end
  end

  // tdo holds outside shift so the last bit stays readable
  always_comb
  begin
    next_tdo = tdo;
    if (shiftIr)
      next_tdo = irShift[0];
    else if (shiftDr)
      next_tdo = drShift[0];
    next_tdoOe = inShift;
  end

  // falling edge gives the far end a half period of setup
  always_ff @(negedge tck or posedge reset)
  begin
    if (reset)
    begin
      tdo <= 1'b0;
      tdoOe <= 1'b0;
    end
    else
    begin
      tdo <= next_tdo;
      tdoOe <= next_tdoOe;
    end
  end

  assign reprogEdge = coreSyncQ[1] ^ reprogLast;

  // suspend is honoured only once configured; the pin is ignored before
  always_comb
  begin
    next_cfgState = cfgState;
    next_loadCount = loadCount;
    next_reprogLast = reprogLast;
    if (clockEnable)
    begin
      next_reprogLast = coreSyncQ[1];
      case (cfgState)
        CFG_CLEAR:
        begin
          next_loadCount = '0;
          next_cfgState = CFG_LOAD;
        end
        CFG_LOAD:
        begin
          if (loadCount == LOAD_LAST)
            next_cfgState = CFG_DONE;
          else
            next_loadCount = loadCount + 1'b1;
        end
        CFG_DONE:
        begin
          if (coreSyncQ[0])
            next_cfgState = CFG_SUSP;
        end
        CFG_SUSP:
        begin
          if (!coreSyncQ[0])
            next_cfgState = CFG_DONE;
        end
        default: next_cfgState = CFG_CLEAR;
      endcase
      if (reprogEdge)
        next_cfgState = CFG_CLEAR;
    end
    next_configDone = (next_cfgState == CFG_DONE) || (next_cfgState == CFG_SUSP);
    next_suspendActive = (next_cfgState == CFG_SUSP);
  end

  always_ff @(posedge clock or posedge coreReset)
  begin
    if (coreReset)
    begin
      cfgState <= CFG_CLEAR;
      loadCount <= '0;
      configDone <= 1'b0;
      suspendActive <= 1'b0;
    end
    else
    begin
      cfgState <= next_cfgState;
      loadCount <= next_loadCount;
      configDone <= next_configDone;
      suspendActive <= next_suspendActive;
    end
  end

  // pin release retimed by two flops so the core leaves reset on a clock edge
  always_comb
  begin
    next_progHold = clockEnable ? {progHold[0], 1'b0} : progHold;
  end

  always_ff @(posedge clock or posedge reset or posedge progPulse)
  begin
    if (reset)
      progHold <= '0;
    else if (progPulse)
      progHold <= '1;
    else
      progHold <= next_progHold;
  end

  // power-on reset only, so a program pulse cannot fake a toggle
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      reprogLast <= 1'b0;
    else
      reprogLast <= next_reprogLast;
  end

  a_tdo_drive_shift: assert property (@(posedge tck) disable iff (reset)
    tdoOe == inShift)
    else $error("tdo enable does not match shift state");

  a_tdo_bypass_path: assert property (@(posedge tck) disable iff (reset)
    (shiftDr && !tapBus.tms && irReg == INS_BYPASS) |=> tdo == $past(tdiEff))
    else $error("bypass bit not presented on tdo");

  a_done_after_load: assert property (@(posedge clock) disable iff (coreReset)
    (cfgState == CFG_LOAD && loadCount == LOAD_LAST && clockEnable && !reprogEdge)
      |=> configDone)
    else $error("done not raised at end of load");

  a_progn_clears_done: assert property (@(posedge clock) disable iff (reset)
    !programResetN |-> (!configDone && !suspendActive))
    else $error("program reset did not clear status");

  a_suspend_enter: assert property (@(posedge clock) disable iff (coreReset)
    (suspendPin && clockEnable && configDone && !reprogEdge) [*4] |=> suspendActive)
    else $error("suspend not entered");

endmodule

// *** testbench/cpj_jtag_host.sv ***
`timescale 1ns/10ps
module cpj_jtag_host (
  // test access port, host side
  output logic tck,
  output logic tms,
  output logic tmsPresent,
  output logic tdi,
  output logic tdiPresent,
  input wire logic tdo,
  input wire logic tdoOe
);
  logic pin;
  logic lastOe;
  logic floatTms;
  logic floatTdi;
  int riseMoves;

  // released pin floats to the pull-up
  assign pin = tdoOe ? tdo : 1'b1;

  initial
  begin
    tck = 1'b0;
    tms = 1'b0;
    tdi = 1'b0;
    tmsPresent = 1'b0;
    tdiPresent = 1'b0;
    floatTms = 1'b0;
    floatTdi = 1'b0;
    riseMoves = 0;
  end

  // any tdo move while tck is high is a wrong-edge update
  always @(tdo or tdoOe)
    if (tck)
      riseMoves++;

  // one tck cycle; tms and tdi settle long before the rising edge
  task automatic clk1(input logic t, input logic d, output logic o);
    tms = t;
    tdi = d;
    tmsPresent = !floatTms;
    tdiPresent = !floatTdi;
    #23;
    o = pin;
    lastOe = tdoOe;
    #1 tck = 1'b1;
    #24 tck = 1'b0;
  endtask

  // between frames tck stands low and the data lines are let go
  task automatic idle();
    tmsPresent = 1'b0;
    tdiPresent = 1'b0;
    tms = ~tms;
    tdi = ~tdi;
    #24;
  endtask

  task automatic toReset();
    logic o;
    repeat (5) clk1(1'b0 | !floatTms, 1'b0, o);
    floatTms = 1'b0;
    clk1(1'b0, 1'b0, o);
    idle();
  endtask

  // from idle: scan n bits lsb first, back to idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout, output logic oeOk);
    logic o;
    dout = '0;
    oeOk = 1'b1;
    clk1(1'b1, 1'b0, o);
    if (ir)
      clk1(1'b1, 1'b0, o);
    clk1(1'b0, 1'b0, o);
    clk1(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++)
    begin
      clk1(i == n - 1, din[i], o);
      dout[i] = o;
      oeOk &= lastOe;
    end
    clk1(1'b1, 1'b0, o);
    oeOk &= !lastOe;
    clk1(1'b0, 1'b0, o);
    idle();
  endtask
endmodule

// *** testbench/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
  import cpj_pkg::*;
  localparam int LOADS = 4;

  logic clock;
  logic reset;
  logic clockEnable;
  logic programResetN;
  logic suspendPin;
  logic configDone;
  logic suspendActive;
  logic tck;
  logic tms;
  logic tmsPresent;
  logic tdi;
  logic tdiPresent;
  logic tdo;
  logic tdoOe;
  logic [7:0] userData;
  logic [31:0] d;
  logic ok;
  int n;
  int fails;
  int nChecks;

  cpj_config_pins #(.LOAD_CYCLES(LOADS)) dut (.clock(clock), .reset(reset), .clockEnable(clockEnable),
    .programResetN(programResetN), .suspendPin(suspendPin), .configDone(configDone),
    .suspendActive(suspendActive), .tck(tck), .tms(tms), .tmsPresent(tmsPresent), .tdi(tdi),
    .tdiPresent(tdiPresent), .tdo(tdo), .tdoOe(tdoOe), .userData(userData));

  cpj_jtag_host host (.tck(tck), .tms(tms), .tmsPresent(tmsPresent), .tdi(tdi),
    .tdiPresent(tdiPresent), .tdo(tdo), .tdoOe(tdoOe));

  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", nChecks, fails);
    if (fails == 0 && nChecks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // counts clock edges until the chosen flag is high
  task automatic waitHigh(input logic sus, output int cnt);
    cnt = 0;
    while ((sus ? suspendActive : configDone) !== 1'b1 && cnt < 200)
    begin
      @(posedge clock);
      #1;
      cnt++;
    end
    if (cnt == 200)
    begin
      fails++;
      conclude();
    end
  endtask

  task automatic tConfig();
    chk("configDone in reset", configDone, 1'b0);
    @(posedge clock);
    reset <= 1'b0;
    waitHigh(1'b0, n);
    chk("edges to configured", n, LOADS + 1);
  endtask

  task automatic tIdcode();
    host.toReset();
    host.scan(1'b0, 32, 32'h0, d, ok);
    chk("idcode", d, ID_CODE_DEF);
    chk("oe only in shift", ok, 1'b1);
    chk("oe idle", tdoOe, 1'b0);
  endtask

  // program reset pulse lands while the user register is mid-shift
  task automatic tUserProg();
    host.scan(1'b1, 4, {28'h0, INS_USER}, d, ok);
    chk("ir capture", d[3:0], IR_CAPTURE);
    fork
      host.scan(1'b0, 8, 32'ha5, d, ok);
      begin
        repeat (30) @(posedge clock);
        programResetN <= 1'b0;
        #1 chk("done drops async", configDone, 1'b0);
        @(posedge clock);
        programResetN <= 1'b1;
      end
    join
    chk("user data kept", userData, 8'ha5);
    chk("oe user shift", ok, 1'b1);
    waitHigh(1'b0, n);
    chk("reconfigured", configDone, 1'b1);
  endtask

  task automatic tBypass();
    host.scan(1'b1, 4, {28'h0, INS_BYPASS}, d, ok);
    host.scan(1'b0, 4, 32'h6, d, ok);
    chk("bypass delay", d[3:0], 4'hc);
    host.floatTdi = 1'b1;
    host.scan(1'b0, 4, 32'h0, d, ok);
    host.floatTdi = 1'b0;
    chk("float tdi high", d[3:0], 4'he);
    host.scan(1'b1, 4, {28'h0, INS_USER}, d, ok);
    host.floatTms = 1'b1;
    host.toReset();
    host.scan(1'b0, 32, 32'h0, d, ok);
    chk("float tms reset", d, ID_CODE_DEF);
  endtask

  task automatic tSuspend();
    @(posedge clock);
    suspendPin <= 1'b1;
    waitHigh(1'b1, n);
    chk("suspend latency", n, 3);
    chk("done in suspend", configDone, 1'b1);
    host.scan(1'b1, 4, {28'h0, INS_STATUS}, d, ok);
    host.scan(1'b0, 2, 32'h0, d, ok);
    chk("status in suspend", d[1:0], 2'b11);
    @(posedge clock);
    suspendPin <= 1'b0;
    repeat (4) @(posedge clock);
    #1 chk("suspend exit", suspendActive, 1'b0);
  endtask

  // reprogram over the test port while the core clock is frozen
  task automatic tReprog();
    host.scan(1'b0, 2, 32'h0, d, ok);
    chk("status configured", d[1:0], 2'b01);
    @(posedge clock);
    clockEnable <= 1'b0;
    host.scan(1'b1, 4, {28'h0, INS_REPROG}, d, ok);
    host.scan(1'b0, 1, 32'h0, d, ok);
    chk("oe reprog shift", ok, 1'b1);
    repeat (10) @(posedge clock);
    #1 chk("done frozen", configDone, 1'b1);
    @(posedge clock);
    clockEnable <= 1'b1;
    repeat (3) @(posedge clock);
    #1 chk("reprog clears done", configDone, 1'b0);
    waitHigh(1'b0, n);
    chk("edges to reconfigured", n, LOADS + 1);
  endtask

  initial
  begin
    fails = 0;
    nChecks = 0;
    reset = 1'b1;
    clockEnable = 1'b1;
    programResetN = 1'b1;
    suspendPin = 1'b0;
    repeat (4) @(posedge clock);
    tConfig();
    #3;
    tIdcode();
    tUserProg();
    tBypass();
    tSuspend();
    tReprog();
    chk("tdo moved on rise", host.riseMoves, 0);
    conclude();
  end
endmodule
